// *** core/sff_dev_end.sv ***
// Slot B fault and common flag registers of the hot-plug controller
//
// Behaviour
// - main-state bit shows real main outputs
// - aux-state bit shows real aux output
// - five overcurrent flags, one per supply
// - flags zero and outputs off after reset
// - command byte 05h selects slot B flags
// - writing one clears flag; last clear releases interrupt
// - reading leaves the fault pin alone
// - mirror bit is one while pin low
// - main fault clears on main request low
// - aux fault clears on aux request low
// - both faults need both requests low
// - register control keeps fault signals inactive
// - register control needs request pins grounded
// - common flag register layout at 06h
// - mask bit suppresses interrupt, no alert response
// - undervoltage flag only while main requested
// - overtemperature trip sets its flag
// - temperature and voltage flags clear by one
// - slot B flag register bit layout
`include "sff_params.svh"

module sff_dev_end #(
  parameter int OC_WIDTH = `SFF_SB_OC_WIDTH
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  sff_link_if.dev                  link,
  input  wire logic                main_on,
  input  wire logic                aux_on,
  input  wire logic [OC_WIDTH-1:0] oc_event,
  input  wire logic                uv_lockout,
  input  wire logic                overtemp_trip,
  input  wire logic                slot_a_gp_input,
  input  wire logic                slot_b_gp_input,
  input  wire logic                register_path_control,
  input  wire logic                main_enable_bit,
  input  wire logic                aux_enable_bit,
  output logic                     main_allow,
  output logic                     aux_allow
);
  import sff_pkg::*;

  if (OC_WIDTH != `SFF_SB_OC_WIDTH) begin : g_chk
    $error("sff_dev_end: OC_WIDTH must match the register layout");
  end

  sff_dev_state_t st_r;
  sff_dev_state_t st_nxt;

  logic [OC_WIDTH-1:0]         oc_flags;
  logic [OC_WIDTH-1:0]         oc_clr;
  logic [`SFF_CF_EVT_WIDTH-1:0] cf_set;
  logic [`SFF_CF_EVT_WIDTH-1:0] cf_clr;
  logic [`SFF_CF_EVT_WIDTH-1:0] cf_flags;
  logic                         take;
  logic                         sel_slot_b;
  logic                         sel_common;
  logic                         main_oc;
  logic                         aux_oc;
  logic                         trip_now;

  // ----------------------------------------------------------------------
  // Register words
  // ----------------------------------------------------------------------
  function automatic logic [7:0] slot_b_word(
    input logic                mirror,
    input logic                main_state,
    input logic                aux_state,
    input logic [OC_WIDTH-1:0] oc
  );
    logic [7:0] w;
    w = `SFF_SLOT_B_FLAGS_RST;
    w[`SFF_SB_TRIP_MIRROR] = mirror;
    w[`SFF_SB_MAIN_ON]     = main_state;
    w[`SFF_SB_AUX_ON]      = aux_state;
    w[`SFF_SB_OC_MSB:0]    = oc;
    return w;
  endfunction

  function automatic logic [7:0] common_word(
    input logic gp_b,
    input logic gp_a,
    input logic suppress,
    input logic uv,
    input logic ot
  );
    logic [7:0] w;
    // Top two bits and bit 0 stay zero
    w = `SFF_COMMON_FLAGS_RST;
    w[`SFF_CF_GP_B]      = gp_b;
    w[`SFF_CF_GP_A]      = gp_a;
    w[`SFF_CF_SUPPRESS]  = suppress;
    w[`SFF_CF_UNDERVOLT] = uv;
    w[`SFF_CF_OVERTEMP]  = ot;
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // A held request is taken once; the ack cycle masks the repeat
  assign take       = link.req && !st_r.ack;
  assign sel_slot_b = (link.cmd == `SFF_CMD_SLOT_B_FLAGS);
  assign sel_common = (link.cmd == `SFF_CMD_COMMON_FLAGS);

  always_comb begin
    oc_clr = '0;
    cf_clr = '0;
    if (take && link.we && sel_slot_b) begin
      oc_clr = link.wdata[`SFF_SB_OC_MSB:0];
    end
    if (take && link.we && sel_common) begin
      cf_clr[1] = link.wdata[`SFF_CF_UNDERVOLT];
      cf_clr[0] = link.wdata[`SFF_CF_OVERTEMP];
    end
  end

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  // Undervoltage only counts while main power was wanted
  assign cf_set[1] = uv_lockout
                     && (link.main_request_pin || main_enable_bit);
  assign cf_set[0] = overtemp_trip;

  sff_sticky_flags #(
    .WIDTH (OC_WIDTH)
  ) u_oc_flags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (oc_event),
    .clr     (oc_clr),
    .flags   (oc_flags)
  );

  sff_sticky_flags #(
    .WIDTH (`SFF_CF_EVT_WIDTH)
  ) u_common_flags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (cf_set),
    .clr     (cf_clr),
    .flags   (cf_flags)
  );

  // ----------------------------------------------------------------------
  // Fault pin latches
  // ----------------------------------------------------------------------
  assign main_oc = |oc_event[`SFF_OC_NEG12:`SFF_OC_THREE];
  assign aux_oc  = oc_event[`SFF_OC_AUX];

  always_comb begin
    st_nxt = st_r;

    // Main trip held until the main request drops; a new trip wins
    if (register_path_control) begin
      st_nxt.main_fault = 1'b0;
    end else if (main_oc) begin
      st_nxt.main_fault = 1'b1;
    end else if (!link.main_request_pin) begin
      st_nxt.main_fault = 1'b0;
    end

    if (register_path_control) begin
      st_nxt.aux_fault = 1'b0;
    end else if (aux_oc) begin
      st_nxt.aux_fault = 1'b1;
    end else if (!link.aux_request_pin) begin
      st_nxt.aux_fault = 1'b0;
    end

    // Pin stays low until both causes are gone
    trip_now = st_nxt.main_fault || st_nxt.aux_fault;
    // Pin depends on fault state only, never on a read
    st_nxt.fault_n = !trip_now;

    // Mask bit is plain read/write
    if (take && link.we && sel_common) begin
      st_nxt.suppress = link.wdata[`SFF_CF_SUPPRESS];
    end

    // Unmapped commands read zero and ignore writes
    st_nxt.ack = take;
    if (take && !link.we) begin
      if (sel_slot_b) begin
        st_nxt.rdata = slot_b_word(!st_r.fault_n, main_on, aux_on,
                                   oc_flags);
      end else if (sel_common) begin
        st_nxt.rdata = common_word(slot_b_gp_input, slot_a_gp_input,
                                   st_r.suppress, cf_flags[1],
                                   cf_flags[0]);
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end

    // Level from the registered flags; clearing the last set flag releases it
    st_nxt.int_n = !((|oc_flags || |cf_flags)
                     && !st_nxt.suppress);

    // Power only while asked for and not tripped
    st_nxt.main_allow = (link.main_request_pin || main_enable_bit)
                        && !st_nxt.main_fault;
    st_nxt.aux_allow  = (link.aux_request_pin || aux_enable_bit)
                        && !st_nxt.aux_fault;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r            <= '0;
      st_r.fault_n    <= 1'b1;
      st_r.int_n      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.ack    = st_r.ack;
  assign link.rdata  = st_r.rdata;
  assign link.trip_n = st_r.fault_n;
  assign link.int_n  = st_r.int_n;
  assign main_allow  = st_r.main_allow;
  assign aux_allow   = st_r.aux_allow;
endmodule

// *** core/sff_params.svh ***
// Constants for the slot B fault flag bank and its register controller
`ifndef SFF_PARAMS_SVH
`define SFF_PARAMS_SVH

// ----------------------------------------------------------------------
// Command bytes of the flag registers
// ----------------------------------------------------------------------
`define SFF_CMD_SLOT_B_FLAGS  8'h05
`define SFF_CMD_COMMON_FLAGS  8'h06
`define SFF_SLOT_B_FLAGS_RST  8'h00
`define SFF_COMMON_FLAGS_RST  8'h00

// ----------------------------------------------------------------------
// Slot B flag register fields
// ----------------------------------------------------------------------
`define SFF_SB_TRIP_MIRROR    7
`define SFF_SB_MAIN_ON        6
`define SFF_SB_AUX_ON         5
`define SFF_SB_OC_MSB         4
`define SFF_SB_OC_WIDTH       5
`define SFF_OC_AUX            4
`define SFF_OC_NEG12          3
`define SFF_OC_POS12          2
`define SFF_OC_FIVE           1
`define SFF_OC_THREE          0

// ----------------------------------------------------------------------
// Common flag register fields
// ----------------------------------------------------------------------
`define SFF_CF_GP_B           5
`define SFF_CF_GP_A           4
`define SFF_CF_SUPPRESS       3
`define SFF_CF_UNDERVOLT      2
`define SFF_CF_OVERTEMP       1
`define SFF_CF_EVT_WIDTH      2

// ----------------------------------------------------------------------
// Controller registers on AHB-Lite (byte addresses)
// ----------------------------------------------------------------------
`define SFF_HOST_CMD_OFS      8'h00
`define SFF_HOST_STATUS_OFS   8'h04
`define SFF_HOST_PINS_OFS     8'h08
`define SFF_HOST_CMD_WE_BIT   16
`define SFF_HOST_ST_BUSY_BIT  8
`define SFF_HOST_ST_INT_BIT   9
`define SFF_HOST_ST_FLT_BIT   10
`define SFF_HOST_PINS_RST     2'h0

`endif

// *** core/sff_pkg.sv ***
// Types shared by the slot B flag bank and its controller
package sff_pkg;

  typedef enum logic [0:0] {
    SFF_HOST_IDLE,
    SFF_HOST_WAIT
  } sff_host_state_t;

  typedef struct packed {
    logic       main_fault;
    logic       aux_fault;
    logic       suppress;
    logic       ack;
    logic [7:0] rdata;
    logic       fault_n;
    logic       int_n;
    logic       main_allow;
    logic       aux_allow;
  } sff_dev_state_t;

  typedef struct packed {
    sff_host_state_t st;
    logic            req;
    logic            we;
    logic [7:0]      cmd;
    logic [7:0]      wdata;
    logic [7:0]      rdata;
    logic [1:0]      pins;
    logic            dp_write;
    logic [7:0]      dp_addr;
    logic [31:0]     hrdata;
    logic            hreadyout;
  } sff_host_state_s_t;

endpackage

// *** core/sff_link_if.sv ***
// Command link and slot pins between controller and flag bank
interface sff_link_if;
  logic       req;
  logic       we;
  logic [7:0] cmd;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       main_request_pin;
  logic       aux_request_pin;
  logic       trip_n;
  logic       int_n;

  modport dev (
    input  req,
    input  we,
    input  cmd,
    input  wdata,
    input  main_request_pin,
    input  aux_request_pin,
    output ack,
    output rdata,
    output trip_n,
    output int_n
  );

  modport host (
    output req,
    output we,
    output cmd,
    output wdata,
    output main_request_pin,
    output aux_request_pin,
    input  ack,
    input  rdata,
    input  trip_n,
    input  int_n
  );
endinterface

// *** core/sff_sticky_flags.sv ***
// Sticky event flags, write-one-to-clear, set beats clear
module sff_sticky_flags #(
  parameter int WIDTH = 5
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flags
);
  import sff_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } sff_sticky_t;

  sff_sticky_t st_r;
  sff_sticky_t st_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("sff_sticky_flags: WIDTH must be at least 1");
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // A clear racing a new event must not hide it
    st_nxt.flags = (st_r.flags & ~clr) | set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;
endmodule

// *** core/sff_host_end.sv ***
// Controller end: AHB-Lite registers drive the flag bank link
`include "sff_params.svh"

module sff_host_end (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  sff_link_if.host         link
);
  import sff_pkg::*;

  sff_host_state_s_t st_r;
  sff_host_state_s_t st_nxt;
  logic              addr_ok;

  // Only whole-word transfers are served
  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.dp_write  = addr_ok && hwrite;
    st_nxt.dp_addr   = haddr[7:0];
    st_nxt.hreadyout = 1'b1;
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `SFF_HOST_CMD_OFS: st_nxt.hrdata = {15'h0000, st_r.we,
                                            st_r.wdata, st_r.cmd};
        `SFF_HOST_STATUS_OFS: st_nxt.hrdata = {21'h000000,
                                               !link.trip_n,
                                               !link.int_n,
                                               st_r.req, st_r.rdata};
        `SFF_HOST_PINS_OFS: st_nxt.hrdata = {30'h00000000, st_r.pins};
        default: st_nxt.hrdata = 32'h00000000;
      endcase
    end

    // Data phase writes; a new command while busy is dropped
    if (st_r.dp_write) begin
      case (st_r.dp_addr)
        `SFF_HOST_CMD_OFS: begin
          if (st_r.st == SFF_HOST_IDLE) begin
            st_nxt.cmd   = hwdata[7:0];
            st_nxt.wdata = hwdata[15:8];
            st_nxt.we    = hwdata[`SFF_HOST_CMD_WE_BIT];
            st_nxt.req   = 1'b1;
            st_nxt.st    = SFF_HOST_WAIT;
          end
        end
        `SFF_HOST_PINS_OFS: st_nxt.pins = hwdata[1:0];
        default: st_nxt.pins = st_r.pins;
      endcase
    end

    case (st_r.st)
      SFF_HOST_IDLE: st_nxt.req = st_nxt.req;
      SFF_HOST_WAIT: begin
        if (link.ack) begin
          st_nxt.req   = 1'b0;
          st_nxt.rdata = st_r.we ? st_r.rdata : link.rdata;
          st_nxt.st    = SFF_HOST_IDLE;
        end
      end
      default: st_nxt.st = SFF_HOST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r           <= '0;
      st_r.st        <= SFF_HOST_IDLE;
      st_r.pins      <= `SFF_HOST_PINS_RST;
      st_r.hreadyout <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata                = st_r.hrdata;
  assign hreadyout             = st_r.hreadyout;
  assign hresp                 = 1'b0;
  assign link.req              = st_r.req;
  assign link.we               = st_r.we;
  assign link.cmd              = st_r.cmd;
  assign link.wdata            = st_r.wdata;
  assign link.main_request_pin = st_r.pins[0];
  assign link.aux_request_pin  = st_r.pins[1];
endmodule

// *** tb/sff_link_monitor.sv ***
// Checker for the command link and slot pins between the two ends
`include "sff_params.svh"

module sff_link_monitor (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] cmd,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       main_request_pin,
  input wire logic       aux_request_pin,
  input wire logic       trip_n,
  input wire logic       int_n
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Command handshake
  // ----------------------------------------------------------------
  ack_one_cycle_a: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property ($rose(req) |=> ack)
    else $error("ack not one cycle after request");
  req_release_a: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  req_hold_a: assert property (req && !ack |=> req && $stable(cmd)
    && $stable(we) && $stable(wdata))
    else $error("request or its fields moved before ack");
  rdata_stands_a: assert property ($changed(rdata) |-> ack && !we)
    else $error("read data moved outside a read answer");

  // ----------------------------------------------------------------
  // Fault pin and interrupt
  // ----------------------------------------------------------------
  reset_idle_a: assert property ($rose(hresetn) |-> trip_n && int_n)
    else $error("fault or interrupt active after reset");
  fault_hold_a: assert property (!trip_n && main_request_pin
    && aux_request_pin |=> !trip_n)
    else $error("fault cleared while both request pins high");
  fault_release_a: assert property (!trip_n && !main_request_pin
    && !aux_request_pin |-> ##[1:2] trip_n)
    else $error("fault kept with both request pins low");
  read_no_effect_a: assert property (ack && !we
    && main_request_pin && aux_request_pin |-> $stable(trip_n))
    else $error("register read moved the fault pin");
  mask_quiet_a: assert property (ack && we
    && cmd == `SFF_CMD_COMMON_FLAGS && wdata[3] |-> ##[1:2] int_n)
    else $error("interrupt active after mask set");
endmodule

// *** tb/slot_fault_flag_registers_tb.sv ***
// Bench joining controller and flag bank, driven over AHB-Lite
`include "sff_params.svh"

module slot_fault_flag_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        main_on;
  logic        aux_on;
  logic [4:0]  oc_event;
  logic        uv_lockout;
  logic        overtemp_trip;
  logic        gp_a;
  logic        gp_b;
  logic        reg_ctl;
  logic        main_en;
  logic        aux_en;
  logic        hresp;
  logic        main_allow;
  logic        aux_allow;
  int          fails;
  int          samples_checked;

  sff_link_if link();

  sff_host_end u_sff_host_end (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link));

  sff_dev_end u_sff_dev_end (.hclk(hclk), .hresetn(hresetn), .link(link),
    .main_on(main_on), .aux_on(aux_on), .oc_event(oc_event),
    .uv_lockout(uv_lockout), .overtemp_trip(overtemp_trip),
    .slot_a_gp_input(gp_a), .slot_b_gp_input(gp_b),
    .register_path_control(reg_ctl), .main_enable_bit(main_en),
    .aux_enable_bit(aux_en), .main_allow(main_allow),
    .aux_allow(aux_allow));

  sff_link_monitor u_sff_link_monitor (.hclk(hclk), .hresetn(hresetn),
    .req(link.req), .we(link.we), .cmd(link.cmd), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata),
    .main_request_pin(link.main_request_pin),
    .aux_request_pin(link.aux_request_pin),
    .trip_n(link.trip_n), .int_n(link.int_n));

  always #20 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bail;
    fails++;
    $display("CHECK FAILED %0t: wait ran out", $time);
    test_done();
  endtask

  // Bounded wait for the slave's ready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) bail();
      @(posedge hclk);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  // One command byte across the link; polls busy until it clears
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    int          n;
    ahb(1'b1, `SFF_HOST_CMD_OFS, {15'h0, w, d, c}, s);
    n = 0;
    s = 32'h100;
    while (s[8] !== 1'b0) begin
      ahb(1'b0, `SFF_HOST_STATUS_OFS, 32'h0, s);
      n++;
      if (n > 20) bail();
    end
    q = s[7:0];
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, c, 8'h00, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, c, d, q);
  endtask

  // Expected interrupt and fault pin state from the status word
  task automatic st(input logic irq, input logic flt);
    logic [31:0] s;
    ahb(1'b0, `SFF_HOST_STATUS_OFS, 32'h0, s);
    chk({30'h0, s[10], s[9]}, {30'h0, flt, irq});
  endtask

  task automatic pins(input logic [1:0] v);
    logic [31:0] s;
    ahb(1'b1, `SFF_HOST_PINS_OFS, {30'h0, v}, s);
  endtask

  task automatic pulse(input logic [6:0] v);
    {overtemp_trip, uv_lockout, oc_event} <= v;
    @(posedge hclk);
    {overtemp_trip, uv_lockout, oc_event} <= 7'h00;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] s;
    chk({29'h0, hresp, main_allow, aux_allow}, 32'h0);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    ahb(1'b0, 8'h0C, 32'h0, s);
    chk(s, 32'h0);
    st(1'b0, 1'b0);
  endtask

  task automatic t_state;
    main_on <= 1'b1;
    rd(8'h05, 8'h40);
    main_on <= 1'b0;
    aux_on <= 1'b1;
    rd(8'h05, 8'h20);
    aux_on <= 1'b0;
    wr(8'h05, 8'hE0);
    rd(8'h05, 8'h00);
    gp_b <= 1'b1;
    rd(8'h06, 8'h20);
    gp_b <= 1'b0;
    gp_a <= 1'b1;
    rd(8'h06, 8'h10);
    gp_a <= 1'b0;
  endtask

  // Each supply alone; only its own request pin may clear the trip
  task automatic t_single;
    logic [7:0] b;
    for (int i = 0; i < 5; i++) begin
      b = 8'h01 << i;
      pins(2'h3);
      pulse({2'b00, b[4:0]});
      rd(8'h05, 8'h80 | b);
      st(1'b1, 1'b1);
      chk({30'h0, main_allow, aux_allow}, i == 4 ? 32'h2 : 32'h1);
      wr(8'h05, b);
      rd(8'h05, 8'h80);
      st(1'b0, 1'b1);
      pins(i == 4 ? 2'h2 : 2'h1);
      rd(8'h05, 8'h80);
      pins(i == 4 ? 2'h1 : 2'h2);
      rd(8'h05, 8'h00);
    end
  endtask

  task automatic t_both;
    pins(2'h3);
    pulse(7'h11);
    wr(8'h05, 8'h11);
    pins(2'h2);
    rd(8'h05, 8'h80);
    pins(2'h0);
    rd(8'h05, 8'h00);
  endtask

  // Register control with both request pins grounded
  task automatic t_regctl;
    pins(2'h0);
    reg_ctl <= 1'b1;
    main_en <= 1'b1;
    aux_en <= 1'b1;
    pulse(7'h04);
    rd(8'h05, 8'h04);
    st(1'b1, 1'b0);
    chk({30'h0, main_allow, aux_allow}, 32'h3);
    wr(8'h05, 8'h04);
    reg_ctl <= 1'b0;
    main_en <= 1'b0;
    aux_en <= 1'b0;
    st(1'b0, 1'b0);
  endtask

  task automatic t_common;
    pulse(7'h20);
    rd(8'h06, 8'h00);
    main_en <= 1'b1;
    pulse(7'h20);
    main_en <= 1'b0;
    rd(8'h06, 8'h04);
    pulse(7'h40);
    rd(8'h06, 8'h06);
    st(1'b1, 1'b0);
    wr(8'h06, 8'h00);
    rd(8'h06, 8'h06);
    wr(8'h06, 8'h08);
    rd(8'h06, 8'h0E);
    st(1'b0, 1'b0);
    wr(8'h06, 8'h0C);
    rd(8'h06, 8'h0A);
    wr(8'h06, 8'h02);
    rd(8'h06, 8'h00);
    st(1'b0, 1'b0);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {main_on, aux_on, oc_event, uv_lockout, overtemp_trip} = '0;
    {gp_a, gp_b, reg_ctl, main_en, aux_en} = 5'h00;
    fails = 0;
    samples_checked = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_state();
    t_single();
    t_both();
    t_regctl();
    t_common();
    test_done();
  end
endmodule
